// ===== dv/test_rbps_top.sv
// Self-checking bench for the strap capture and bus pin select register.
// Assumes the design answers reads one cycle after the read strobe.
`timescale 1ns/1ps
module test_rbps_top;
  logic        ref_clk_i, reset_i, ce_i, clk_src_sel_i, io_wr_i, io_rd_i;
  logic [15:0] io_addr_i, io_wdata_i, io_rdata_o, rd_val;
  logic        main_clk_ext_o;
  logic [20:0] pp_pin_o, pp_pin_oe_n_o;
  logic [5:0]  sp1_pin_o, sp1_pin_oe_n_o, sp2_pin_o, sp2_pin_oe_n_o;
  logic [5:0]  addr_o, addr_oe_n_o;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  // Distinct source patterns so a wrong route shows up as a wrong value.
  logic [20:0] lcd  = 21'h1B2C3D;
  logic [6:0]  spi  = 7'h5A;
  logic [3:0]  uart = 4'h9, i2s2 = 4'h6, i2s3 = 4'hC;
  logic [7:0]  ppg  = 8'hE7, ppg_oe = 8'h3C;
  logic [5:0]  c1 = 6'h2B, g1 = 6'h35, c2 = 6'h14, g2 = 6'h0A;
  logic [5:0]  go1 = 6'h0F, go2 = 6'h30;
  // Sources never move, as gated peripherals would hold still.
  // No peripheral is used between rewrites, so none needs a reset, and the
  // repeated rewrites go beyond what software may do.
  logic [3:0]  s1 = 4'hD, s2 = 4'h3;
  logic [5:0]  emif = 6'h2A, ag = 6'h15, ag_oe = 6'h33;

  rbps_top u_rbps_top (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .clk_src_sel_i(clk_src_sel_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .main_clk_ext_o(main_clk_ext_o),
    .lcd_out_i(lcd), .spi_out_i(spi), .uart_out_i(uart),
    .i2s2_out_i(i2s2), .i2s3_out_i(i2s3), .pp_gpio_out_i(ppg),
    .pp_gpio_oe_n_i(ppg_oe), .pp_pin_o(pp_pin_o),
    .pp_pin_oe_n_o(pp_pin_oe_n_o), .sp1_card_out_i(c1),
    .sp1_i2s_out_i(s1), .sp1_gpio_out_i(g1), .sp1_gpio_oe_n_i(go1),
    .sp2_card_out_i(c2), .sp2_i2s_out_i(s2), .sp2_gpio_out_i(g2),
    .sp2_gpio_oe_n_i(go2), .sp1_pin_o(sp1_pin_o),
    .sp1_pin_oe_n_o(sp1_pin_oe_n_o), .sp2_pin_o(sp2_pin_o),
    .sp2_pin_oe_n_o(sp2_pin_oe_n_o), .emif_addr_i(emif),
    .addr_gpio_out_i(ag), .addr_gpio_oe_n_i(ag_oe),
    .memory_address_pins_o(addr_o),
    .memory_address_pins_oe_n_o(addr_oe_n_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // The strap is only captured while reset is held, so it is set first.
  task automatic do_reset(input logic strap);
    @(negedge ref_clk_i);
    clk_src_sel_i = strap;
    reset_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    reset_i = 1'b0;
    @(negedge ref_clk_i);
  endtask

  // A spare edge first keeps back-to-back writes from driving the strobe
  // twice in one time step.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge ref_clk_i);
    io_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge ref_clk_i);
    io_rd_i = 1'b0;
    d = io_rdata_o;
    @(negedge ref_clk_i);
  endtask

  function automatic logic [20:0] pp_exp(input int m);
    case (m)
      0: pp_exp = lcd;
      1: pp_exp = {uart, i2s2, ppg[5:0], spi};
      2: pp_exp = {5'h00, ppg, lcd[7:0]};
      3: pp_exp = {5'h00, i2s3, spi[3:0], lcd[7:0]};
      4: pp_exp = {5'h00, uart, i2s2, lcd[7:0]};
      5: pp_exp = {5'h00, uart, spi[3:0], lcd[7:0]};
      default: pp_exp = 21'h000000;
    endcase
  endfunction

  function automatic logic [20:0] pp_oe_exp(input int m);
    case (m)
      0: pp_oe_exp = 21'h000000;
      1: pp_oe_exp = {8'h00, ppg_oe[5:0], 7'h00};
      2: pp_oe_exp = {5'h1F, ppg_oe, 8'h00};
      3, 4, 5: pp_oe_exp = 21'h1F0000;
      default: pp_oe_exp = 21'h1FFFFF;
    endcase
  endfunction

  function automatic logic [5:0] sp_exp(input int m, input logic [5:0] c,
                                        input logic [3:0] s,
                                        input logic [5:0] g);
    case (m)
      0: sp_exp = c;
      1: sp_exp = {g[5:4], s};
      2: sp_exp = g;
      default: sp_exp = 6'h00;
    endcase
  endfunction

  function automatic logic [5:0] sp_oe_exp(input int m,
                                           input logic [5:0] g_oe);
    case (m)
      0: sp_oe_exp = 6'h00;
      1: sp_oe_exp = {g_oe[5:4], 4'h0};
      2: sp_oe_exp = g_oe;
      default: sp_oe_exp = 6'h3F;
    endcase
  endfunction

  task automatic t_strap;
    do_reset(1'b1);
    chk(main_clk_ext_o, 21'h1);
    do_reset(1'b0);
    chk(main_clk_ext_o, 21'h0);
    $display("strap test done");
  endtask

  task automatic t_reset_state;
    chk(pp_pin_o, lcd);
    chk(pp_pin_oe_n_o, 21'h0);
    chk(sp1_pin_o, c1);
    chk(sp1_pin_oe_n_o, 21'h0);
    chk(sp2_pin_o, c2);
    chk(addr_o, emif);
    chk(addr_oe_n_o, 21'h0);
    rd(16'h1C00, rd_val);
    chk(rd_val, 21'h0);
    $display("reset state test done");
  endtask

  task automatic t_register;
    wr(16'h1C00, 16'hFFFF);
    rd(16'h1C00, rd_val);
    chk(rd_val, 21'h7F3F);
    wr(16'h1C01, 16'h0000);
    rd(16'h1C00, rd_val);
    chk(rd_val, 21'h7F3F);
    rd(16'h1C01, rd_val);
    chk(rd_val, 21'h0);
    $display("register test done");
  endtask

  // Each check lands at the falling edge right after the write edge.
  task automatic t_parallel;
    for (int m = 0; m < 8; m++) begin
      wr(16'h1C00, 16'(m << 12));
      chk(pp_pin_o, pp_exp(m));
      chk(pp_pin_oe_n_o, pp_oe_exp(m));
    end
    $display("parallel port test done");
  endtask

  task automatic t_serial;
    for (int m = 0; m < 4; m++) begin
      wr(16'h1C00, 16'((m << 10) | ((3 - m) << 8)));
      chk(sp1_pin_o, sp_exp(m, c1, s1, g1));
      chk(sp2_pin_o, sp_exp(3 - m, c2, s2, g2));
      chk(sp1_pin_oe_n_o, sp_oe_exp(m, go1));
      chk(sp2_pin_oe_n_o, sp_oe_exp(3 - m, go2));
    end
    $display("serial port test done");
  endtask

  task automatic t_address;
    logic [5:0] sel;
    for (int k = 0; k < 2; k++) begin
      sel = (k == 0) ? 6'h15 : 6'h2A;
      wr(16'h1C00, {10'h000, sel});
      chk(addr_o, (ag & sel) | (emif & ~sel));
      chk(addr_oe_n_o, ag_oe & sel);
    end
    $display("address pin test done");
  endtask

  // A write while the enable is low must leave register and pins alone.
  task automatic t_enable;
    ce_i = 1'b0;
    wr(16'h1C00, 16'h5000);
    chk(pp_pin_o, lcd);
    chk(addr_o, (ag & 6'h2A) | (emif & 6'h15));
    ce_i = 1'b1;
    rd(16'h1C00, rd_val);
    chk(rd_val, 21'h002A);
    $display("clock enable test done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The tests need about 60 cycles; this 3000-cycle limit leaves ample margin.
  initial begin
    #(3000 * 100);
    n_mismatch++;
    conclude();
  end

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    clk_src_sel_i = 1'b0;
    io_addr_i = 16'h0000;
    io_wdata_i = 16'h0000;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    t_strap();
    t_reset_state();
    t_register();
    t_parallel();
    t_serial();
    t_address();
    t_enable();
    conclude();
  end
endmodule

// ===== logic/rbps_pkg.sv
// Constants for the reset configuration and external bus pin select block.
// Assumes a 16-bit CPU I/O port space and a 10 MHz reference clock.
package rbps_pkg;

  // Register location and layout.
  localparam logic [15:0] SEL_ADDR       = 16'h1C00;
  localparam logic [15:0] SEL_RESET      = 16'h0000;
  localparam logic [15:0] SEL_WRITE_MASK = 16'h7F3F;
  localparam logic [15:0] SEL_RSVD_VALUE = 16'h0000;
  localparam int          RSVD_BIT       = 15;
  localparam int          PP_MSB         = 14;
  localparam int          PP_LSB         = 12;
  localparam int          SP1_MSB        = 11;
  localparam int          SP1_LSB        = 10;
  localparam int          SP2_MSB        = 9;
  localparam int          SP2_LSB        = 8;
  localparam int          AGPIO_MSB      = 5;
  localparam int          AGPIO_LSB      = 0;

  // Pin counts.
  localparam int PP_PINS    = 21;
  localparam int SP_PINS    = 6;
  localparam int ADDR_PINS  = 6;

  // Parallel port route codes.
  localparam logic [2:0] PP_LCD16          = 3'h0;
  localparam logic [2:0] PP_SPI_GPIO       = 3'h1;
  localparam logic [2:0] PP_LCD8_GPIO      = 3'h2;
  localparam logic [2:0] PP_LCD8_SPI_I2S3  = 3'h3;
  localparam logic [2:0] PP_LCD8_I2S2_UART = 3'h4;
  localparam logic [2:0] PP_LCD8_SPI_UART  = 3'h5;

  // Serial port route codes.
  localparam logic [1:0] SP_CARD     = 2'h0;
  localparam logic [1:0] SP_I2S_GPIO = 2'h1;
  localparam logic [1:0] SP_GPIO     = 2'h2;

endpackage

// ===== logic/rbps_serial_route.sv
// Pin router for one six-pin serial port: card, audio plus GPIO, or GPIO.
// Assumes the mode given is the value the select register takes this edge.
`timescale 1ns/1ps
module rbps_serial_route (
  // Clock and control
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] next_mode_i,
  // Peripheral sources
  input  wire logic [5:0] card_out_i,
  input  wire logic [3:0] i2s_out_i,
  input  wire logic [5:0] gpio_out_i,
  input  wire logic [5:0] gpio_oe_n_i,
  // Pads
  output logic      [5:0] pin_o,
  output logic      [5:0] pin_oe_n_o
);

  logic [5:0] next_pin;
  logic [5:0] next_oe_n;

  always_comb begin
    case (next_mode_i)
      rbps_pkg::SP_CARD: begin
        next_pin  = card_out_i;
        next_oe_n = 6'h00;
      end
      rbps_pkg::SP_I2S_GPIO: begin
        next_pin  = {gpio_out_i[5:4], i2s_out_i};
        next_oe_n = {gpio_oe_n_i[5:4], 4'h0};
      end
      rbps_pkg::SP_GPIO: begin
        next_pin  = gpio_out_i;
        next_oe_n = gpio_oe_n_i;
      end
      default: begin
        // The reserved code releases every pin rather than guess a route.
        next_pin  = 6'h00;
        next_oe_n = 6'h3F;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_o      <= 6'h00;
      pin_oe_n_o <= 6'h3F;
    end else if (ce_i) begin
      pin_o      <= next_pin;
      pin_oe_n_o <= next_oe_n;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sp_card_route_a: assert property (
    ce_i && next_mode_i == rbps_pkg::SP_CARD
    |=> pin_o == $past(card_out_i) && pin_oe_n_o == 6'h00)
    else $error("Card route not on serial pins.");

  sp_reserved_off_a: assert property (
    ce_i && next_mode_i == 2'h3 |=> pin_oe_n_o == 6'h3F)
    else $error("Reserved serial mode drives pins.");

  sp_audio_route_a: assert property (
    ce_i && next_mode_i == rbps_pkg::SP_I2S_GPIO
    |=> pin_o[3:0] == $past(i2s_out_i) && pin_oe_n_o[3:0] == 4'h0)
    else $error("Audio route not on serial pins.");

endmodule

// ===== logic/rbps_top.sv
// Reset clock-source strap and external bus pin selection register.
// Assumes a CPU I/O port bus on ref_clk_i and pad logic outside.
//
// Contract
// - Select pin low: internal oscillator clocks everything.
// - Select pin high: external clock feeds clock generator.
// - Register routes peripherals onto 21 parallel pins.
// - Register routes audio or card to serial ports.
// - Register decoded at I/O port 0x1C00.
// - New routing takes effect next CPU clock.
// - Each address pin 20..15 selectable as GPIO.
// - Bit 15 reserved, reads fixed, ignores writes.
// - Bits 14:12 pick parallel port routing mode.
// - Bits 11:10 pick serial port 1 routing.
`timescale 1ns/1ps
module rbps_top (
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Clock source strap pin
  input  wire logic        clk_src_sel_i,
  // CPU I/O port bus
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [15:0] io_wdata_i,
  output logic      [15:0] io_rdata_o,
  // Clock source selection
  output logic             main_clk_ext_o,
  // Parallel port sources
  input  wire logic [20:0] lcd_out_i,
  input  wire logic [6:0]  spi_out_i,
  input  wire logic [3:0]  uart_out_i,
  input  wire logic [3:0]  i2s2_out_i,
  input  wire logic [3:0]  i2s3_out_i,
  input  wire logic [7:0]  pp_gpio_out_i,
  input  wire logic [7:0]  pp_gpio_oe_n_i,
  // Parallel port pads
  output logic      [20:0] pp_pin_o,
  output logic      [20:0] pp_pin_oe_n_o,
  // Serial port sources
  input  wire logic [5:0]  sp1_card_out_i,
  input  wire logic [3:0]  sp1_i2s_out_i,
  input  wire logic [5:0]  sp1_gpio_out_i,
  input  wire logic [5:0]  sp1_gpio_oe_n_i,
  input  wire logic [5:0]  sp2_card_out_i,
  input  wire logic [3:0]  sp2_i2s_out_i,
  input  wire logic [5:0]  sp2_gpio_out_i,
  input  wire logic [5:0]  sp2_gpio_oe_n_i,
  // Serial port pads
  output logic      [5:0]  sp1_pin_o,
  output logic      [5:0]  sp1_pin_oe_n_o,
  output logic      [5:0]  sp2_pin_o,
  output logic      [5:0]  sp2_pin_oe_n_o,
  // Memory address pin sources and pads
  input  wire logic [5:0]  emif_addr_i,
  input  wire logic [5:0]  addr_gpio_out_i,
  input  wire logic [5:0]  addr_gpio_oe_n_i,
  output logic      [5:0]  memory_address_pins_o,
  output logic      [5:0]  memory_address_pins_oe_n_o
);

  logic [2:0]  sel_sync;
  logic [15:0] external_bus_pin_select;
  logic [15:0] next_select;
  logic        sel_hit;
  logic [20:0] next_pp_pin;
  logic [20:0] next_pp_oe_n;
  logic [5:0]  next_agpio;

  // Strap is sampled every cycle that ce_i is high but only trusted while reset holds.
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      sel_sync <= {sel_sync[1:0], clk_src_sel_i};
    end
  end

  // The source stays frozen after release, so a strap change is ignored.
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && reset_i && sel_sync[1] == sel_sync[2]) begin
      main_clk_ext_o <= sel_sync[2];
    end
  end

  assign sel_hit = (io_addr_i == rbps_pkg::SEL_ADDR);

  always_comb begin
    next_select = external_bus_pin_select;
    if (io_wr_i && sel_hit) begin
      next_select = (io_wdata_i & rbps_pkg::SEL_WRITE_MASK) |
                    rbps_pkg::SEL_RSVD_VALUE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      external_bus_pin_select <= rbps_pkg::SEL_RESET;
    end else if (ce_i) begin
      external_bus_pin_select <= next_select;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      io_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      if (io_rd_i && sel_hit) begin
        io_rdata_o <= external_bus_pin_select;
      end else begin
        io_rdata_o <= 16'h0000;
      end
    end
  end

  // Routing is computed from the incoming value so pins follow a write
  // at the same edge that stores it.
  always_comb begin
    next_pp_pin  = 21'h000000;
    next_pp_oe_n = 21'h1FFFFF;
    case (next_select[rbps_pkg::PP_MSB:rbps_pkg::PP_LSB])
      rbps_pkg::PP_LCD16: begin
        next_pp_pin  = lcd_out_i;
        next_pp_oe_n = 21'h000000;
      end
      rbps_pkg::PP_SPI_GPIO: begin
        next_pp_pin  = {uart_out_i, i2s2_out_i, pp_gpio_out_i[5:0],
                        spi_out_i};
        next_pp_oe_n = {8'h00, pp_gpio_oe_n_i[5:0], 7'h00};
      end
      rbps_pkg::PP_LCD8_GPIO: begin
        next_pp_pin  = {5'h00, pp_gpio_out_i, lcd_out_i[7:0]};
        next_pp_oe_n = {5'h1F, pp_gpio_oe_n_i, 8'h00};
      end
      rbps_pkg::PP_LCD8_SPI_I2S3: begin
        next_pp_pin  = {5'h00, i2s3_out_i, spi_out_i[3:0], lcd_out_i[7:0]};
        next_pp_oe_n = {5'h1F, 16'h0000};
      end
      rbps_pkg::PP_LCD8_I2S2_UART: begin
        next_pp_pin  = {5'h00, uart_out_i, i2s2_out_i, lcd_out_i[7:0]};
        next_pp_oe_n = {5'h1F, 16'h0000};
      end
      rbps_pkg::PP_LCD8_SPI_UART: begin
        next_pp_pin  = {5'h00, uart_out_i, spi_out_i[3:0], lcd_out_i[7:0]};
        next_pp_oe_n = {5'h1F, 16'h0000};
      end
      default: begin
        next_pp_pin  = 21'h000000;
        next_pp_oe_n = 21'h1FFFFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pp_pin_o      <= 21'h000000;
      pp_pin_oe_n_o <= 21'h1FFFFF;
    end else if (ce_i) begin
      pp_pin_o      <= next_pp_pin;
      pp_pin_oe_n_o <= next_pp_oe_n;
    end
  end

  assign next_agpio = next_select[rbps_pkg::AGPIO_MSB:rbps_pkg::AGPIO_LSB];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      memory_address_pins_o      <= 6'h00;
      memory_address_pins_oe_n_o <= 6'h00;
    end else if (ce_i) begin
      for (int i = 0; i < rbps_pkg::ADDR_PINS; i++) begin
        if (next_agpio[i]) begin
          memory_address_pins_o[i]      <= addr_gpio_out_i[i];
          memory_address_pins_oe_n_o[i] <= addr_gpio_oe_n_i[i];
        end else begin
          memory_address_pins_o[i]      <= emif_addr_i[i];
          memory_address_pins_oe_n_o[i] <= 1'b0;
        end
      end
    end
  end

  rbps_serial_route u_sp1 (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .next_mode_i (next_select[rbps_pkg::SP1_MSB:rbps_pkg::SP1_LSB]),
    .card_out_i  (sp1_card_out_i),
    .i2s_out_i   (sp1_i2s_out_i),
    .gpio_out_i  (sp1_gpio_out_i),
    .gpio_oe_n_i (sp1_gpio_oe_n_i),
    .pin_o       (sp1_pin_o),
    .pin_oe_n_o  (sp1_pin_oe_n_o)
  );

  rbps_serial_route u_sp2 (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .next_mode_i (next_select[rbps_pkg::SP2_MSB:rbps_pkg::SP2_LSB]),
    .card_out_i  (sp2_card_out_i),
    .i2s_out_i   (sp2_i2s_out_i),
    .gpio_out_i  (sp2_gpio_out_i),
    .gpio_oe_n_i (sp2_gpio_oe_n_i),
    .pin_o       (sp2_pin_o),
    .pin_oe_n_o  (sp2_pin_oe_n_o)
  );

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence sel_write_s;
    ce_i && io_wr_i && io_addr_i == rbps_pkg::SEL_ADDR;
  endsequence

  sequence sel_read_s;
    ce_i && io_rd_i && io_addr_i == rbps_pkg::SEL_ADDR;
  endsequence

  clk_src_frozen_a: assert property (
    ##1 $stable(main_clk_ext_o))
    else $error("Clock source changed outside reset.");

  strap_capture_a: assert property (
    disable iff (1'b0)
    reset_i && ce_i && sel_sync[1] == sel_sync[2]
    |=> main_clk_ext_o == $past(sel_sync[2]))
    else $error("Strap not captured during reset.");

  write_readback_a: assert property (
    sel_write_s ##1 (sel_read_s and !io_wr_i)
    |=> io_rdata_o == ($past(io_wdata_i, 2) & rbps_pkg::SEL_WRITE_MASK))
    else $error("Readback differs from written value.");

  reserved_bit_a: assert property (
    external_bus_pin_select[rbps_pkg::RSVD_BIT] == 1'b0 &&
    io_rdata_o[rbps_pkg::RSVD_BIT] == 1'b0)
    else $error("Reserved bit not fixed.");

  decode_miss_a: assert property (
    ce_i && io_addr_i != rbps_pkg::SEL_ADDR
    |=> $stable(external_bus_pin_select) && io_rdata_o == 16'h0000)
    else $error("Access outside 0x1C00 had an effect.");

  lcd_route_a: assert property (
    sel_write_s ##0 io_wdata_i[14:12] == rbps_pkg::PP_LCD16
    |=> pp_pin_o == $past(lcd_out_i) && pp_pin_oe_n_o == 21'h000000)
    else $error("LCD route not applied on next clock.");

  spi_uart_route_a: assert property (
    sel_write_s ##0 io_wdata_i[14:12] == rbps_pkg::PP_LCD8_SPI_UART
    |=> pp_pin_o[15:8] == {$past(uart_out_i), $past(spi_out_i[3:0])}
        && pp_pin_oe_n_o[20:16] == 5'h1F)
    else $error("SPI and UART route not applied on next clock.");

  addr_gpio_a: assert property (
    ce_i && next_agpio[0]
    |=> memory_address_pins_o[0] == $past(addr_gpio_out_i[0]))
    else $error("Address pin not handed to GPIO.");

  addr_emif_a: assert property (
    ce_i && !next_agpio[5]
    |=> memory_address_pins_o[5] == $past(emif_addr_i[5]) &&
        !memory_address_pins_oe_n_o[5])
    else $error("Address pin lost memory function.");

  sp1_field_a: assert property (
    sel_write_s ##0 io_wdata_i[11:10] == rbps_pkg::SP_GPIO
    |=> sp1_pin_o == $past(sp1_gpio_out_i))
    else $error("Serial port 1 GPIO route not applied.");

endmodule
